// [core/nvs_ctrl.sv]
// How it works
// - Array is 1024 rows of one word
// - Erase sector is two aligned rows
// - Byte/aligned read one cycle, misaligned two
// - Erased bit reads 1, programmed 0
// - No valid read data while busy
// - Sector erase and mass erase commands
// - Three-step write sequence launches commands
// - Protection byte stored at array 0x07FD
// - Top protected sector sized 64 to 512 bytes
// - Global open bit clear blocks program and erase, not verify
// - Twelve byte registers at offsets 0x0-0xB
// - Factory test registers read zero, read-only
// - Interrupts on all-done and buffer empty
// - No chip pins, internal bus only
// - Protection register reset to 0x00, loaded from array in the first cycle after reset
// - Enabled flags request command interrupt
// - Protected program/erase sets violation flag
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module nvs_ctrl
    import nvs_pkg::*;
#(
    parameter int PROG_TICKS = nvs_pkg::NVS_PROG_TICKS,
    parameter int ERASE_TICKS = nvs_pkg::NVS_ERASE_TICKS
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [10:0] arr_addr,
    input wire logic [15:0] arr_wdata,
    input wire logic arr_wr,
    input wire logic arr_rd,
    input wire logic arr_word,
    output logic [15:0] arr_rdata,
    output logic arr_rvalid,
    output logic arr_rbusy,
    output logic cmd_irq
);
    import nvs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage and state
    // Cells power up erased; reset never touches them, so the stored setting survives
    logic [15:0] mem [0:NVS_ROWS-1] = '{default: NVS_ERASED_WORD};
    logic [7:0] div_r;
    logic [1:0] cfg_r;
    logic [7:0] prot_r;
    logic ld_done_r;
    logic pv_r;
    logic ae_r;
    logic blank_r;
    logic [7:0] cmd_code_r;
    logic [9:0] cmd_row_r;
    logic [15:0] cmd_data_r;
    nvs_seq_t seq_r;
    logic buf_valid_r;
    logic [7:0] buf_cmd_r;
    logic [9:0] buf_row_r;
    logic [15:0] buf_data_r;
    nvs_ex_t ex_r;
    logic [7:0] ex_cmd_r;
    logic [15:0] ex_data_r;
    logic [15:0] ex_cnt_r;
    logic [9:0] ap_row_r;
    logic [9:0] ap_end_r;
    logic vfy_ok_r;
    logic [2:0] pre_cnt_r;
    logic [5:0] tick_cnt_r;
    logic mis_pend_r;
    logic [7:0] mis_hi_r;
    logic [9:0] mis_row_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and derived status
    logic wr_div, wr_cfg, wr_prot, wr_stat, wr_cmd;
    logic buffer_empty_flag, all_done_flag, seq_ready, seq_err, valid_code;
    logic launch_try, launch_blocked, launch_ok, take;
    logic prot_open, range_on, any_protect, cmd_prot;
    logic [10:0] sector_lo;
    logic pre_tick, tick, ex_busy;
    logic [15:0] rd_row;

    assign wr_div = reg_wr && reg_addr == NVS_OFF_DIV;
    assign wr_cfg = reg_wr && reg_addr == NVS_OFF_CFG;
    assign wr_prot = reg_wr && reg_addr == NVS_OFF_PROT;
    assign wr_stat = reg_wr && reg_addr == NVS_OFF_STAT;
    assign wr_cmd = reg_wr && reg_addr == NVS_OFF_CMD;

    // Buffer empty while the holding stage is free; done once both are idle
    assign ex_busy = ex_r != NVS_EX_IDLE;
    assign buffer_empty_flag = !buf_valid_r;
    assign all_done_flag = !buf_valid_r && !ex_busy;

    // Protected window grows downward from the top in 64-byte steps
    assign prot_open = prot_r[NVS_PROT_OPEN_BIT];
    assign range_on = !prot_r[NVS_PROT_DIS_BIT];
    assign sector_lo = NVS_PROT_BASE0 - {2'b00, prot_r[2:0], 6'h00};
    assign any_protect = !prot_open || range_on;
    assign cmd_prot = !prot_open || (range_on && {cmd_row_r, 1'b0} >= sector_lo);

    assign valid_code = reg_wdata == NVS_CMD_VERIFY || reg_wdata == NVS_CMD_PROGRAM
        || reg_wdata == NVS_CMD_SECTOR_ERASE || reg_wdata == NVS_CMD_MASS_ERASE;
    // A sequence may only start with a free buffer and clean error flags
    assign seq_ready = buffer_empty_flag && !pv_r && !ae_r && div_r[NVS_DIV_LOADED_BIT] && ld_done_r;
    assign launch_try = wr_stat && reg_wdata[NVS_STAT_BE_BIT] && seq_r == NVS_SEQ_CMD;
    // Verify never alters the array, so protection does not apply to it
    assign launch_blocked = (cmd_code_r == NVS_CMD_MASS_ERASE) ? any_protect
        : (cmd_code_r != NVS_CMD_VERIFY && cmd_prot);
    assign launch_ok = launch_try && !launch_blocked;
    assign take = buf_valid_r && !ex_busy;
    // Out-of-order steps of the write sequence
    assign seq_err = (arr_wr && !(seq_r == NVS_SEQ_IDLE && seq_ready))
        || (wr_cmd && !(seq_r == NVS_SEQ_ADDR && valid_code))
        || (wr_stat && reg_wdata[NVS_STAT_BE_BIT] && seq_r != NVS_SEQ_CMD);

    assign pre_tick = !div_r[NVS_DIV_PRE8_BIT] || pre_cnt_r == NVS_PRE8_LAST;
    assign tick = pre_tick && tick_cnt_r == div_r[5:0];
    assign rd_row = mem[arr_addr[10:1]];

    // Command interrupt from enabled flags
    assign cmd_irq = (buffer_empty_flag && cfg_r[1]) || (all_done_flag && cfg_r[0]);

    ////////////////////////////////////////////////////////////////////////////
    // Timing divider: write once, sets the loaded bit
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= NVS_DIV_RST;
        else if (wr_div && !div_r[NVS_DIV_LOADED_BIT])
            div_r <= {1'b1, reg_wdata[6:0]};
    end

    // Tick generator for the operation timers
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_cnt_r <= 3'h0;
            tick_cnt_r <= 6'h00;
        end
        else
        begin
            pre_cnt_r <= pre_cnt_r + 3'h1;
            if (tick)
                tick_cnt_r <= 6'h00;
            else if (pre_tick)
                tick_cnt_r <= tick_cnt_r + 6'h01;
        end
    end

    // Interrupt enables
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= NVS_CFG_RST;
        else if (wr_cfg)
            cfg_r <= {reg_wdata[NVS_CFG_BE_IE_BIT], reg_wdata[NVS_CFG_DONE_IE_BIT]};
    end

    // Protection: loaded from the array after reset, then only tightened
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prot_r <= NVS_PROT_RST;
            ld_done_r <= 1'b0;
        end
        else if (!ld_done_r)
        begin
            prot_r <= mem[NVS_PROT_ROW][7:0];
            ld_done_r <= 1'b1;
        end
        else if (wr_prot)
        begin
            prot_r[NVS_PROT_OPEN_BIT] <= prot_r[NVS_PROT_OPEN_BIT] & reg_wdata[7];
            prot_r[NVS_PROT_DIS_BIT] <= prot_r[NVS_PROT_DIS_BIT] & reg_wdata[3];
            if (prot_r[NVS_PROT_DIS_BIT])
                prot_r[2:0] <= reg_wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write sequence: array write, command write, then buffer-empty clear
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seq_r <= NVS_SEQ_IDLE;
            cmd_code_r <= 8'h00;
            cmd_row_r <= 10'h000;
            cmd_data_r <= 16'h0000;
        end
        else if (arr_wr)
        begin
            if (seq_r == NVS_SEQ_IDLE && seq_ready)
            begin
                cmd_row_r <= arr_addr[10:1];
                cmd_data_r <= arr_wdata;
                seq_r <= NVS_SEQ_ADDR;
            end
            else
                seq_r <= NVS_SEQ_IDLE;
        end
        else if (wr_cmd)
        begin
            if (seq_r == NVS_SEQ_ADDR && valid_code)
            begin
                cmd_code_r <= reg_wdata;
                seq_r <= NVS_SEQ_CMD;
            end
            else
                seq_r <= NVS_SEQ_IDLE;
        end
        else if (wr_stat && reg_wdata[NVS_STAT_BE_BIT])
            seq_r <= NVS_SEQ_IDLE;
        else if (reg_wr && seq_r == NVS_SEQ_IDLE)
        begin
            // Direct software writes only outside a sequence
            case (reg_addr)
                NVS_OFF_ADDR_HI: cmd_row_r[9:8] <= reg_wdata[1:0];
                NVS_OFF_ADDR_LO: cmd_row_r[7:0] <= reg_wdata;
                NVS_OFF_DATA_HI: cmd_data_r[15:8] <= reg_wdata;
                NVS_OFF_DATA_LO: cmd_data_r[7:0] <= reg_wdata;
                default: cmd_row_r <= cmd_row_r;
            endcase
        end
    end

    // Error flags: a set in the clearing cycle wins
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pv_r <= 1'b0;
            ae_r <= 1'b0;
        end
        else
        begin
            pv_r <= (launch_try && launch_blocked)
                || (pv_r && !(wr_stat && reg_wdata[NVS_STAT_PV_BIT]));
            ae_r <= seq_err || (ae_r && !(wr_stat && reg_wdata[NVS_STAT_AE_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command buffer stage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_valid_r <= 1'b0;
            buf_cmd_r <= 8'h00;
            buf_row_r <= 10'h000;
            buf_data_r <= 16'h0000;
        end
        else if (launch_ok)
        begin
            buf_valid_r <= 1'b1;
            buf_cmd_r <= cmd_code_r;
            buf_row_r <= cmd_row_r;
            buf_data_r <= cmd_data_r;
        end
        else if (take)
            buf_valid_r <= 1'b0;
    end

    // Execution stage: wait the timed interval, then sweep the rows
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ex_r <= NVS_EX_IDLE;
            ex_cmd_r <= 8'h00;
            ex_data_r <= 16'h0000;
            ex_cnt_r <= 16'h0000;
            ap_row_r <= 10'h000;
            ap_end_r <= 10'h000;
            vfy_ok_r <= 1'b0;
            blank_r <= 1'b0;
        end
        else
        begin
            case (ex_r)
                NVS_EX_IDLE:
                begin
                    if (take)
                    begin
                        ex_r <= NVS_EX_WAIT;
                        ex_cmd_r <= buf_cmd_r;
                        ex_data_r <= buf_data_r;
                        blank_r <= 1'b0;
                        vfy_ok_r <= 1'b1;
                        case (buf_cmd_r)
                            NVS_CMD_PROGRAM:
                            begin
                                ex_cnt_r <= 16'(PROG_TICKS);
                                ap_row_r <= buf_row_r;
                                ap_end_r <= buf_row_r;
                            end
                            NVS_CMD_SECTOR_ERASE:
                            begin
                                ex_cnt_r <= 16'(ERASE_TICKS);
                                ap_row_r <= {buf_row_r[9:1], 1'b0};
                                ap_end_r <= {buf_row_r[9:1], 1'b1};
                            end
                            NVS_CMD_MASS_ERASE:
                            begin
                                ex_cnt_r <= 16'(ERASE_TICKS);
                                ap_row_r <= 10'h000;
                                ap_end_r <= NVS_LAST_ROW;
                            end
                            default:
                            begin
                                ex_cnt_r <= NVS_VERIFY_TICKS;
                                ap_row_r <= 10'h000;
                                ap_end_r <= NVS_LAST_ROW;
                            end
                        endcase
                    end
                end
                NVS_EX_WAIT:
                begin
                    if (tick)
                    begin
                        if (ex_cnt_r <= 16'h0001)
                            ex_r <= NVS_EX_APPLY;
                        else
                            ex_cnt_r <= ex_cnt_r - 16'h0001;
                    end
                end
                NVS_EX_APPLY:
                begin
                    if (mem[ap_row_r] != NVS_ERASED_WORD)
                        vfy_ok_r <= 1'b0;
                    if (ap_row_r == ap_end_r)
                    begin
                        ex_r <= NVS_EX_IDLE;
                        blank_r <= ex_cmd_r == NVS_CMD_VERIFY && vfy_ok_r
                            && mem[ap_row_r] == NVS_ERASED_WORD;
                    end
                    else
                        ap_row_r <= ap_row_r + 10'h001;
                end
                default: ex_r <= NVS_EX_IDLE;
            endcase
        end
    end

    // Array cells: no reset, erase drives bits to 1, program only clears
    always_ff @(posedge core_clk)
    begin
        if (ex_r == NVS_EX_APPLY && ex_cmd_r != NVS_CMD_VERIFY)
        begin
            if (ex_cmd_r == NVS_CMD_PROGRAM)
                mem[ap_row_r] <= mem[ap_row_r] & ex_data_r;
            else
                mem[ap_row_r] <= NVS_ERASED_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array read port; a misaligned word needs a second row fetch
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arr_rdata <= 16'h0000;
            arr_rvalid <= 1'b0;
            arr_rbusy <= 1'b0;
            mis_pend_r <= 1'b0;
            mis_hi_r <= 8'h00;
            mis_row_r <= 10'h000;
        end
        else
        begin
            arr_rvalid <= 1'b0;
            arr_rbusy <= arr_rd && ex_busy;
            if (mis_pend_r)
            begin
                mis_pend_r <= 1'b0;
                arr_rvalid <= 1'b1;
                arr_rdata <= {mis_hi_r, mem[mis_row_r][15:8]};
            end
            else if (arr_rd && !ex_busy)
            begin
                if (!arr_word)
                begin
                    arr_rvalid <= 1'b1;
                    arr_rdata <= {8'h00, arr_addr[0] ? rd_row[7:0] : rd_row[15:8]};
                end
                else if (!arr_addr[0])
                begin
                    arr_rvalid <= 1'b1;
                    arr_rdata <= rd_row;
                end
                else
                begin
                    mis_pend_r <= 1'b1;
                    mis_hi_r <= rd_row[7:0];
                    mis_row_r <= arr_addr[10:1] + 10'h001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read data, one cycle after the strobe; test slots read zero
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                NVS_OFF_DIV: reg_rdata <= div_r;
                NVS_OFF_CFG: reg_rdata <= {cfg_r, 6'h00};
                NVS_OFF_PROT: reg_rdata <= prot_r;
                NVS_OFF_STAT: reg_rdata <= {buffer_empty_flag, all_done_flag, pv_r, ae_r, 1'b0, blank_r, 2'b00};
                NVS_OFF_CMD: reg_rdata <= cmd_code_r;
                NVS_OFF_ADDR_HI: reg_rdata <= {6'h00, cmd_row_r[9:8]};
                NVS_OFF_ADDR_LO: reg_rdata <= cmd_row_r[7:0];
                NVS_OFF_DATA_HI: reg_rdata <= cmd_data_r[15:8];
                NVS_OFF_DATA_LO: reg_rdata <= cmd_data_r[7:0];
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    AST_IRQ_FLAGS: assert property (
        cmd_irq == ((!buf_valid_r && cfg_r[1]) || (!buf_valid_r && !ex_busy && cfg_r[0])))
        else $error("command interrupt does not match flags and enables");
    AST_NO_READ_BUSY: assert property (
        arr_rd && ex_busy && !mis_pend_r |=> !arr_rvalid && arr_rbusy)
        else $error("read data delivered during an operation");
    AST_ALIGNED_ONE: assert property (
        arr_rd && !ex_busy && !mis_pend_r && !(arr_word && arr_addr[0]) |=> arr_rvalid)
        else $error("aligned read not answered in one cycle");
    AST_MISALIGNED_TWO: assert property (
        arr_rd && !ex_busy && !mis_pend_r && arr_word && arr_addr[0]
        |=> !arr_rvalid ##1 arr_rvalid)
        else $error("misaligned read not answered in two cycles");
    AST_TEST_ZERO: assert property (
        reg_rd && (reg_addr == NVS_OFF_FT_A || reg_addr == NVS_OFF_FT_B
        || reg_addr == NVS_OFF_FT_C) |=> reg_rdata == 8'h00)
        else $error("factory test register not zero");
    AST_PROTECTION_VIOLATION_FLAG_SET: assert property (
        launch_try && launch_blocked |=> pv_r && !buf_valid_r)
        else $error("protected launch not flagged");
    AST_GLOBAL_LOCK: assert property (
        !prot_open && launch_try && cmd_code_r != NVS_CMD_VERIFY |=> !buf_valid_r)
        else $error("command launched while array closed");
    AST_LAUNCH_BUSY: assert property (
        launch_ok |=> !buffer_empty_flag && !all_done_flag ##1 !all_done_flag)
        else $error("launch did not clear buffer-empty and done");
    AST_PROT_LOAD: assert property (
        rst_n && !ld_done_r |=> prot_r == $past(mem[NVS_PROT_ROW][7:0]))
        else $error("protection not loaded from array");
    AST_SECTOR_PAIR: assert property (
        ex_r == NVS_EX_IDLE && take && buf_cmd_r == NVS_CMD_SECTOR_ERASE
        |=> ap_row_r[0] == 1'b0 && ap_end_r == (ap_row_r | 10'h001))
        else $error("sector erase does not span two aligned rows");

    COV_PROGRAM: cover property (launch_ok && cmd_code_r == NVS_CMD_PROGRAM);
    COV_MASS: cover property (launch_ok && cmd_code_r == NVS_CMD_MASS_ERASE);
    COV_MISALIGNED: cover property (mis_pend_r ##1 arr_rvalid);
    COV_PROTECTION_VIOLATION_FLAG: cover property ($rose(pv_r));

endmodule : nvs_ctrl

// [core/nvs_pkg.sv]
package nvs_pkg;

    // Register map, one byte per offset
    localparam logic [3:0] NVS_OFF_DIV = 4'h0;
    localparam logic [3:0] NVS_OFF_FT_A = 4'h1;
    localparam logic [3:0] NVS_OFF_FT_B = 4'h2;
    localparam logic [3:0] NVS_OFF_CFG = 4'h3;
    localparam logic [3:0] NVS_OFF_PROT = 4'h4;
    localparam logic [3:0] NVS_OFF_STAT = 4'h5;
    localparam logic [3:0] NVS_OFF_CMD = 4'h6;
    localparam logic [3:0] NVS_OFF_FT_C = 4'h7;
    localparam logic [3:0] NVS_OFF_ADDR_HI = 4'h8;
    localparam logic [3:0] NVS_OFF_ADDR_LO = 4'h9;
    localparam logic [3:0] NVS_OFF_DATA_HI = 4'ha;
    localparam logic [3:0] NVS_OFF_DATA_LO = 4'hb;

    // Array organisation
    localparam int NVS_ROWS = 1024;
    localparam logic [9:0] NVS_LAST_ROW = 10'h3ff;
    localparam logic [9:0] NVS_PROT_ROW = 10'h3fe;
    localparam logic [15:0] NVS_ERASED_WORD = 16'hffff;
    localparam logic [10:0] NVS_PROT_BASE0 = 11'h7c0;

    // Field positions
    localparam int NVS_DIV_LOADED_BIT = 7;
    localparam int NVS_DIV_PRE8_BIT = 6;
    localparam int NVS_CFG_BE_IE_BIT = 7;
    localparam int NVS_CFG_DONE_IE_BIT = 6;
    localparam int NVS_PROT_OPEN_BIT = 7;
    localparam int NVS_PROT_DIS_BIT = 3;
    localparam int NVS_STAT_BE_BIT = 7;
    localparam int NVS_STAT_PV_BIT = 5;
    localparam int NVS_STAT_AE_BIT = 4;

    // Reset values
    localparam logic [7:0] NVS_DIV_RST = 8'h00;
    localparam logic [1:0] NVS_CFG_RST = 2'h0;
    localparam logic [7:0] NVS_PROT_RST = 8'h00;

    // Command codes
    localparam logic [7:0] NVS_CMD_VERIFY = 8'h05;
    localparam logic [7:0] NVS_CMD_PROGRAM = 8'h20;
    localparam logic [7:0] NVS_CMD_SECTOR_ERASE = 8'h40;
    localparam logic [7:0] NVS_CMD_MASS_ERASE = 8'h41;

    // Prescaler last count, then operation lengths in divided timing ticks
    localparam logic [2:0] NVS_PRE8_LAST = 3'h7;
    localparam int NVS_PROG_TICKS = 6;
    localparam int NVS_ERASE_TICKS = 4000;
    localparam logic [15:0] NVS_VERIFY_TICKS = 16'h0001;

    typedef enum {NVS_SEQ_IDLE, NVS_SEQ_ADDR, NVS_SEQ_CMD} nvs_seq_t;
    typedef enum {NVS_EX_IDLE, NVS_EX_WAIT, NVS_EX_APPLY} nvs_ex_t;

endpackage : nvs_pkg

// [test/small_sector_nv_store_ctrl_bench.sv]
`timescale 1ns/100ps
module small_sector_nv_store_ctrl_bench;
    import nvs_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [10:0] arr_addr = 11'h000;
    logic [15:0] arr_wdata = 16'h0000;
    logic arr_wr = 1'b0;
    logic arr_rd = 1'b0;
    logic arr_word = 1'b0;
    logic [15:0] arr_rdata;
    logic arr_rvalid;
    logic arr_rbusy;
    logic cmd_irq;
    int err_total = 0;
    int samples_checked = 0;
    logic [7:0] rv;

    // Short tick counts keep the run brief
    nvs_ctrl #(.PROG_TICKS(1), .ERASE_TICKS(2)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
        .arr_wr(arr_wr), .arr_rd(arr_rd), .arr_word(arr_word), .arr_rdata(arr_rdata),
        .arr_rvalid(arr_rvalid), .arr_rbusy(arr_rbusy), .cmd_irq(cmd_irq));

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus helpers; each leaves one idle edge so no strobe is driven twice in a step
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    // First step of a command: address and data through the array port
    task automatic aw(input logic [10:0] a, input logic [15:0] d);
        @(posedge core_clk);
        arr_addr <= a;
        arr_wdata <= d;
        arr_wr <= 1'b1;
        @(posedge core_clk);
        arr_wr <= 1'b0;
    endtask : aw

    // Poll the status until the all-done flag shows
    task automatic wait_done();
        int n;
        n = 0;
        rd(NVS_OFF_STAT);
        while (!rv[6] && n < 100)
        begin
            rd(NVS_OFF_STAT);
            n++;
        end
    endtask : wait_done

    // Array read; a misaligned word answers one cycle later
    task automatic ard(input logic [10:0] a, input logic w, input logic [15:0] e);
        @(posedge core_clk);
        arr_addr <= a;
        arr_word <= w;
        arr_rd <= 1'b1;
        @(posedge core_clk);
        arr_rd <= 1'b0;
        if (w && a[0])
            @(posedge core_clk);
        #1 chk("arr_rvalid", 16'h0001, {15'h0000, arr_rvalid});
        chk("arr_rdata", e, arr_rdata);
    endtask : ard

    task automatic t_prog();
        // Erase the sector first: a word is never programmed twice without it
        aw(11'h010, 16'hffff);
        wr(NVS_OFF_CMD, NVS_CMD_SECTOR_ERASE);
        wr(NVS_OFF_STAT, 8'h80);
        wait_done();
        chk("erase status", 8'hc0, rv & 8'hf0);
        aw(11'h010, 16'h1234);
        wr(NVS_OFF_CMD, NVS_CMD_PROGRAM);
        wr(NVS_OFF_STAT, 8'h80);
        wait_done();
        chk("program status", 8'hc0, rv & 8'hf0);
        ard(11'h010, 1'b1, 16'h1234);
        ard(11'h011, 1'b0, 16'h0034);
        ard(11'h011, 1'b1, 16'h34ff);
        $display("test prog done");
    endtask : t_prog

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [3:0] rs [4] = '{4'h1, 4'h2, 4'h7, 4'hc};
        foreach (rs[i])
        begin
            wr(rs[i], 8'hff);
            rd(rs[i]);
            chk("reserved", 8'h00, rv);
        end
        wr(NVS_OFF_CFG, 8'hff);
        rd(NVS_OFF_CFG);
        chk("interrupt_config", 8'hc0, rv);
        wr(NVS_OFF_CFG, 8'h00);
        // Divider is write-once, loaded bit sets on the first write
        wr(NVS_OFF_DIV, 8'h01);
        wr(NVS_OFF_DIV, 8'h3f);
        rd(NVS_OFF_DIV);
        chk("timing_divider", 8'h81, rv);
        $display("test regs done");
    endtask : t_regs

    task automatic t_prot();
        logic [7:0] cs [3] = '{NVS_CMD_PROGRAM, NVS_CMD_SECTOR_ERASE, NVS_CMD_MASS_ERASE};
        wr(NVS_OFF_PROT, 8'h00);
        rd(NVS_OFF_PROT);
        chk("protection_setting", 8'h00, rv & 8'h88);
        foreach (cs[i])
        begin
            aw(11'h010, 16'h1234);
            wr(NVS_OFF_CMD, cs[i]);
            wr(NVS_OFF_STAT, 8'h80);
            rd(NVS_OFF_STAT);
            chk("status after refused", 8'he0, rv & 8'hf0);
            wr(NVS_OFF_STAT, 8'h20);
            rd(NVS_OFF_STAT);
            chk("violation cleared", 8'hc0, rv & 8'hf0);
        end
        // Command code without the address step is out of order
        wr(NVS_OFF_CMD, NVS_CMD_PROGRAM);
        rd(NVS_OFF_STAT);
        chk("access error", 8'hd0, rv & 8'hf0);
        wr(NVS_OFF_STAT, 8'h10);
        $display("test prot done");
    endtask : t_prot

    task automatic t_verify();
        int n;
        wr(NVS_OFF_CFG, 8'h40);
        #1 chk("irq idle", 8'h01, {7'h00, cmd_irq});
        aw(11'h000, 16'h0000);
        wr(NVS_OFF_CMD, NVS_CMD_VERIFY);
        wr(NVS_OFF_STAT, 8'h80);
        @(posedge core_clk);
        arr_addr <= 11'h000;
        arr_word <= 1'b1;
        arr_rd <= 1'b1;
        @(posedge core_clk);
        arr_rd <= 1'b0;
        #1 chk("rbusy", 8'h01, {7'h00, arr_rbusy});
        chk("rvalid", 8'h00, {7'h00, arr_rvalid});
        chk("irq busy", 8'h00, {7'h00, cmd_irq});
        n = 0;
        while (cmd_irq !== 1'b1 && n < 5000)
        begin
            @(posedge core_clk);
            n++;
        end
        // Verify walks 1024 rows after one tick of two cycles
        chk("verify length", 8'h01, {7'h00, n > 1020 && n < 1100});
        // The programmed word keeps the array from counting as blank
        rd(NVS_OFF_STAT);
        chk("verify status", 8'hc0, rv & 8'hf4);
        wr(NVS_OFF_CFG, 8'h80);
        #1 chk("irq empty", 8'h01, {7'h00, cmd_irq});
        wr(NVS_OFF_CFG, 8'h00);
        #1 chk("irq masked", 8'h00, {7'h00, cmd_irq});
        $display("test verify done");
    endtask : t_verify

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    // Main sequence
    initial
    begin
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_regs();
        t_prog();
        t_prot();
        t_verify();
        close_out();
    end

    // Watchdog well beyond the roughly 1200 cycles the tests need
    initial
    begin
        #200000;
        err_total++;
        close_out();
    end
endmodule : small_sector_nv_store_ctrl_bench
